// ---- hdl/chri_pkg.sv ----
// Package of constants for the processor control-input block
`default_nettype none
package chri_pkg;
    localparam logic [7:0] CHRI_NMI_VECTOR = 8'h02;
    localparam logic [1:0] CHRI_IRQ_LEAD = 2'h2;
    localparam logic [1:0] CHRI_ACK_CYCLES = 2'h2;
    localparam logic [2:0] CHRI_NMI_LOW_MIN = 3'h4;
    typedef enum logic [2:0] {
        CHRI_IDLE,
        CHRI_BUS,
        CHRI_FLOAT,
        CHRI_HELD,
        CHRI_INTA
    } chri_state_type;
endpackage
`default_nettype wire

// ---- hdl/chri_sync.sv ----
// Two-stage synchroniser for one asynchronous input
`default_nettype none
module chri_sync
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Level
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb
    begin
        next_stage1 = clk_en ? async_in : stage1;
        next_sync_out = clk_en ? stage1 : sync_out;
        if (!rst_n)
        begin
            next_stage1 = 1'b0;
            next_sync_out = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end
endmodule
`default_nettype wire

// ---- hdl/chri_ctrl.sv ----
// Bus-cycle extension, hold handshake and interrupt input control
`default_nettype none
module chri_ctrl
    import chri_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Core side
    input wire logic cycle_req,
    input wire logic instr_end,
    input wire logic int_enable,
    output logic cycle_done,
    output logic irq_taken,
    output logic [7:0] irq_vector,
    // Local bus pins
    input wire logic ready_n,
    input wire logic hold_req,
    output logic bus_grant_ack,
    output logic bus_drive_oe,
    output logic inta_cycle,
    input wire logic [7:0] vector_in,
    // Interrupt pins
    input wire logic maskable_irq_req,
    input wire logic nmi_req
);
    // Synchronised pins
    logic hold_sync;
    logic irq_sync;
    logic nmi_sync;

    // Non-maskable edge qualifier
    logic nmi_prev;
    logic [2:0] nmi_low_cnt;
    logic nmi_pend;
    logic nmi_clear;
    logic next_nmi_prev;
    logic [2:0] next_nmi_low_cnt;
    logic next_nmi_pend;

    // Maskable level age
    logic [1:0] irq_age;
    logic [1:0] next_irq_age;

    // Control state
    chri_state_type state;
    chri_state_type next_state;
    logic [1:0] ack_cnt;
    logic [1:0] next_ack_cnt;
    logic next_cycle_done;
    logic next_irq_taken;
    logic [7:0] next_irq_vector;
    logic next_bus_grant_ack;
    logic next_bus_drive_oe;
    logic next_inta_cycle;

    // The hold and both interrupt pins pass two flip-flops first; ready_n does not
    chri_sync u_hold_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(hold_req),
        .sync_out(hold_sync)
    );

    chri_sync u_irq_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(maskable_irq_req),
        .sync_out(irq_sync)
    );

    chri_sync u_nmi_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(nmi_req),
        .sync_out(nmi_sync)
    );

    // Edge qualifier for the non-maskable input
    always_comb
    begin
        next_nmi_prev = nmi_sync;
        next_nmi_low_cnt = nmi_low_cnt;
        next_nmi_pend = nmi_pend;
        if (!nmi_sync)
        begin
            if (nmi_low_cnt != CHRI_NMI_LOW_MIN)
            begin
                next_nmi_low_cnt = nmi_low_cnt + 3'h1;
            end
        end
        else
        begin
            next_nmi_low_cnt = 3'h0;
        end
        if (nmi_clear)
        begin
            next_nmi_pend = 1'b0;
        end
        // A fresh edge wins over the clear of the one just taken
        if (nmi_sync && !nmi_prev && nmi_low_cnt == CHRI_NMI_LOW_MIN)
        begin
            next_nmi_pend = 1'b1;
        end
        // Frozen while the clock enable is low
        if (!clk_en)
        begin
            next_nmi_prev = nmi_prev;
            next_nmi_low_cnt = nmi_low_cnt;
            next_nmi_pend = nmi_pend;
        end
        if (!rst_n)
        begin
            next_nmi_prev = 1'b0;
            next_nmi_low_cnt = 3'h0;
            next_nmi_pend = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        nmi_prev <= next_nmi_prev;
        nmi_low_cnt <= next_nmi_low_cnt;
        nmi_pend <= next_nmi_pend;
    end

    // Age of the synchronised maskable level
    always_comb
    begin
        next_irq_age = irq_age;
        if (irq_sync)
        begin
            if (irq_age != CHRI_IRQ_LEAD)
            begin
                next_irq_age = irq_age + 2'h1;
            end
        end
        else
        begin
            next_irq_age = 2'h0;
        end
        // Frozen while the clock enable is low
        if (!clk_en)
        begin
            next_irq_age = irq_age;
        end
        if (!rst_n)
        begin
            next_irq_age = 2'h0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        irq_age <= next_irq_age;
    end

    // Bus ownership, cycle control and interrupt entry
    always_comb
    begin
        next_state = state;
        next_ack_cnt = ack_cnt;
        next_cycle_done = 1'b0;
        next_irq_taken = 1'b0;
        next_irq_vector = irq_vector;
        next_bus_grant_ack = bus_grant_ack;
        next_bus_drive_oe = bus_drive_oe;
        next_inta_cycle = 1'b0;
        nmi_clear = 1'b0;

        unique case (state)
            // Hold first; a cycle in progress is never cut
            CHRI_IDLE:
            begin
                if (hold_sync)
                begin
                    next_bus_drive_oe = 1'b0;
                    next_state = CHRI_FLOAT;
                end
                else if (instr_end && nmi_pend)
                begin
                    nmi_clear = 1'b1;
                    next_irq_taken = 1'b1;
                    next_irq_vector = CHRI_NMI_VECTOR;
                end
                else if (instr_end && int_enable
                         && irq_age == CHRI_IRQ_LEAD)
                begin
                    next_ack_cnt = 2'h0;
                    next_inta_cycle = 1'b1;
                    next_state = CHRI_INTA;
                end
                else if (cycle_req)
                begin
                    next_state = CHRI_BUS;
                end
            end
            // Stretched until the ready input goes low
            CHRI_BUS:
            begin
                if (!ready_n)
                begin
                    next_cycle_done = 1'b1;
                    next_state = CHRI_IDLE;
                end
            end
            CHRI_FLOAT:
            begin
                next_bus_grant_ack = 1'b1;
                next_state = CHRI_HELD;
            end
            CHRI_HELD:
            begin
                if (!hold_sync)
                begin
                    next_bus_grant_ack = 1'b0;
                    next_bus_drive_oe = 1'b1;
                    next_state = CHRI_IDLE;
                end
            end
            // Vector comes with the end of the second acknowledge
            CHRI_INTA:
            begin
                next_inta_cycle = 1'b1;
                if (!ready_n)
                begin
                    next_ack_cnt = ack_cnt + 2'h1;
                    next_inta_cycle = 1'b0;
                    if (ack_cnt + 2'h1 == CHRI_ACK_CYCLES)
                    begin
                        next_irq_vector = vector_in;
                        next_irq_taken = 1'b1;
                        next_state = CHRI_IDLE;
                    end
                end
            end
        endcase

        // Frozen while the clock enable is low
        if (!clk_en)
        begin
            next_state = state;
            next_ack_cnt = ack_cnt;
            next_cycle_done = cycle_done;
            next_irq_taken = irq_taken;
            next_irq_vector = irq_vector;
            next_bus_grant_ack = bus_grant_ack;
            next_bus_drive_oe = bus_drive_oe;
            next_inta_cycle = inta_cycle;
        end
        // Synchronous reset
        if (!rst_n)
        begin
            next_state = CHRI_IDLE;
            next_ack_cnt = 2'h0;
            next_cycle_done = 1'b0;
            next_irq_taken = 1'b0;
            next_irq_vector = 8'h00;
            next_bus_grant_ack = 1'b0;
            next_bus_drive_oe = 1'b1;
            next_inta_cycle = 1'b0;
        end
    end

    // Every output of the block is a flip-flop
    always_ff @(posedge clk_sys)
    begin
        state <= next_state;
        ack_cnt <= next_ack_cnt;
        cycle_done <= next_cycle_done;
        irq_taken <= next_irq_taken;
        irq_vector <= next_irq_vector;
        bus_grant_ack <= next_bus_grant_ack;
        bus_drive_oe <= next_bus_drive_oe;
        inta_cycle <= next_inta_cycle;
    end
endmodule
`default_nettype wire

// ---- dv/chri_ctrl_properties.sv ----
// Port assertions for the control-input block
`default_nettype none
module chri_ctrl_properties
    import chri_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Watched ports
    input wire logic ready_n,
    input wire logic hold_req,
    input wire logic cycle_done,
    input wire logic irq_taken,
    input wire logic [7:0] irq_vector,
    input wire logic bus_grant_ack,
    input wire logic bus_drive_oe,
    input wire logic inta_cycle
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_grant_floats: assert property (bus_grant_ack |-> !bus_drive_oe)
        else $error("grant while driving");
    a_float_first: assert property (
        $rose(bus_grant_ack) |-> $past(!bus_drive_oe)) else $error("no float");
    a_grant_cause: assert property (
        $rose(bus_grant_ack) |-> $past(hold_req, 2)) else $error("bad grant");
    a_hold_release: assert property (
        $fell(hold_req) |-> ##[1:5] !bus_grant_ack) else $error("grant stuck");
    a_oe_back: assert property ($fell(bus_grant_ack) |-> bus_drive_oe)
        else $error("bus not retaken");
    a_done_ready: assert property (
        cycle_done |-> $past(!ready_n) || $past(!ready_n, 2))
        else $error("cycle ended early");
    a_ack_ends: assert property (
        $fell(inta_cycle) |-> $past(!ready_n) || $past(!ready_n, 2))
        else $error("ack ended early");
    a_nmi_no_ack: assert property (
        irq_taken && !$past(inta_cycle) |-> irq_vector == CHRI_NMI_VECTOR)
        else $error("vector taken without ack is wrong");
    a_busy_no_grant: assert property (inta_cycle |-> !bus_grant_ack)
        else $error("grant in ack");
    c_grant: cover property ($rose(bus_grant_ack));
    c_nmi: cover property (irq_taken && irq_vector == CHRI_NMI_VECTOR);
    c_irq: cover property (irq_taken && irq_vector != CHRI_NMI_VECTOR);
endmodule
bind chri_ctrl chri_ctrl_properties i_chri_ctrl_properties (
    .clk_sys(clk_sys), .rst_n(rst_n), .ready_n(ready_n),
    .hold_req(hold_req), .cycle_done(cycle_done), .irq_taken(irq_taken),
    .irq_vector(irq_vector), .bus_grant_ack(bus_grant_ack),
    .bus_drive_oe(bus_drive_oe), .inta_cycle(inta_cycle));
`default_nettype wire

// ---- dv/chri_bus_partner.sv ----
// Wait-state and interrupt-controller model
`default_nettype none
module chri_bus_partner
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Cycle in progress, wait length, vector
    input wire logic active,
    input wire logic [2:0] wait_len,
    input wire logic [7:0] vec,
    // Answers
    output logic ready_n = 1'b1,
    output logic [7:0] vector_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt = 3'h0;
    logic ended = 1'b0;
    always @(posedge clk_sys)
    begin
        ready_n <= 1'b1;
        if (!rst_n || !active)
        begin
            cnt <= 3'h0;
            ended <= 1'b0;
        end
        else if (!ended && cnt == wait_len)
        begin
            ready_n <= 1'b0;
            ended <= 1'b1;
        end
        else
            cnt <= cnt + 3'h1;
    end
    // Wrong value outside a cycle
    assign vector_in = active ? vec : ~vec;
endmodule
`default_nettype wire

// ---- dv/chri_ctrl_tb_top.sv ----
// Self-checking bench for the control-input block
`default_nettype none
module chri_ctrl_tb_top;
    import chri_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_n = 1'b0, cycle_req = 1'b0, instr_end = 1'b0;
    logic int_enable = 1'b0, hold_req = 1'b0, busy = 1'b0;
    logic maskable_irq_req = 1'b0, nmi_req = 1'b0;
    logic [2:0] wait_len = 3'h0;
    logic [7:0] vec = 8'h0, irq_vector, vector_in;
    logic cycle_done, irq_taken, ready_n, bus_grant_ack, bus_drive_oe;
    logic inta_cycle;
    int miscompares = 0, n_tests = 0, inta_seen = 0, n, k;
    chri_ctrl i_chri_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
        .cycle_req(cycle_req), .instr_end(instr_end), .int_enable(int_enable),
        .cycle_done(cycle_done), .irq_taken(irq_taken),
        .irq_vector(irq_vector), .ready_n(ready_n), .hold_req(hold_req),
        .bus_grant_ack(bus_grant_ack), .bus_drive_oe(bus_drive_oe),
        .inta_cycle(inta_cycle), .vector_in(vector_in),
        .maskable_irq_req(maskable_irq_req), .nmi_req(nmi_req));
    chri_bus_partner i_chri_bus_partner (.clk_sys(clk_sys), .rst_n(rst_n),
        .active(inta_cycle | busy), .wait_len(wait_len), .vec(vec),
        .ready_n(ready_n), .vector_in(vector_in));
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge inta_cycle) inta_seen++;
    always @(negedge inta_cycle) maskable_irq_req <= 1'b0;
    function logic pick(input int sel);
        pick = sel == 0 ? cycle_done : sel == 1 ? bus_grant_ack : irq_taken;
    endfunction
    task check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("%0d compares, %0d wrong", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task wait_on(input int sel, input logic lvl, output int cnt);
        for (cnt = 0; cnt < 300; cnt++)
        begin
            @(posedge clk_sys);
            #1;
            if (pick(sel) === lvl)
                return;
        end
        miscompares++;
        report_and_stop();
    endtask
    initial
    begin
        void'($urandom(32'h9bc7));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk_sys);
            wait_len <= k == 0 ? 3'h7 : 3'($urandom_range(7));
            cycle_req <= 1'b1;
            busy <= 1'b1;
            @(posedge clk_sys);
            cycle_req <= 1'b0;
            wait_on(0, 1'b1, n);
            check(8'(n >= int'(wait_len)), 8'h1);
            @(posedge clk_sys);
            busy <= 1'b0;
        end
        $display("bus cycle test over");
        @(posedge clk_sys);
        wait_len <= 3'h7;
        cycle_req <= 1'b1;
        busy <= 1'b1;
        @(posedge clk_sys);
        cycle_req <= 1'b0;
        hold_req <= 1'b1;
        wait_on(0, 1'b1, n);
        check(8'({bus_grant_ack, bus_drive_oe}), 8'h1);
        @(posedge clk_sys);
        busy <= 1'b0;
        wait_on(1, 1'b1, n);
        check(8'(bus_drive_oe), 8'h0);
        n = $urandom_range(12, 3);
        for (k = 0; k < n; k++)
        begin
            @(posedge clk_sys);
            cycle_req <= 1'b1;
            #1 check(8'({bus_grant_ack, bus_drive_oe}), 8'h2);
        end
        @(posedge clk_sys);
        hold_req <= 1'b0;
        wait_on(1, 1'b0, n);
        check(8'(bus_drive_oe), 8'h1);
        @(posedge clk_sys);
        cycle_req <= 1'b0;
        busy <= 1'b1;
        wait_on(0, 1'b1, n);
        check(8'(n >= int'(wait_len)), 8'h1);
        $display("hold test over");
        @(posedge clk_sys);
        busy <= 1'b0;
        vec <= 8'($urandom_range(255, 3));
        instr_end <= 1'b1;
        maskable_irq_req <= 1'b1;
        repeat (10) @(posedge clk_sys);
        check(8'(inta_seen), 8'h0);
        int_enable <= 1'b1;
        wait_on(2, 1'b1, n);
        check(irq_vector, vec);
        check(8'(inta_seen), CHRI_ACK_CYCLES);
        $display("maskable test over");
        @(posedge clk_sys);
        int_enable <= 1'b0;
        nmi_req <= 1'b1;
        wait_on(2, 1'b1, n);
        check(irq_vector, CHRI_NMI_VECTOR);
        check(8'(inta_seen), CHRI_ACK_CYCLES);
        $display("nmi test over");
        report_and_stop();
    end
endmodule
`default_nettype wire
